// *** hw/ftb_sram_port.sv ***
/*
  Flow-through burst SRAM port: input registers, burst counter, write decode,
  data-line enables, sleep sequencing.
  Assumes a host that drives synchronous inputs on the falling clock edge.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ftb_defines.svh"
module ftb_sram_port
  import ftb_pkg::*;
#(
  parameter int AW = `FTB_ADDR_W,
  parameter int LANES = `FTB_LANES,
  parameter int LW = `FTB_LANE_W
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // address and control
  input wire logic [AW-1:0] addr,
  input wire logic proc_addr_strobe_n,
  input wire logic ctrl_addr_strobe_n,
  input wire logic burst_advance_n,
  input wire logic chip_select_a_n,
  input wire logic chip_select_b,
  input wire logic chip_select_c_n,
  input wire logic global_write_n,
  input wire logic byte_write_enable_n,
  input wire logic [LANES-1:0] byte_lane_select_n,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic burst_order,
  // data lines, parity bit is the top bit of each lane
  input wire logic [LANES*LW-1:0] data_in,
  output logic [LANES*LW-1:0] data_out,
  output logic [LANES*LW-1:0] data_oe_n,
  // status
  output logic asleep
);
  localparam int DW = LANES*LW;
  localparam int SLP = `FTB_SLEEP_CYCLES;
  initial
  begin
    if (AW < 2 || LANES < 1 || LW < 1)
      $error("ftb_sram_port: unsupported parameters");
  end

  // ---------------------------------
  // state
  // ---------------------------------
  typedef struct packed {
    logic [AW-1:0] addr;
    logic [1:0] start;
    logic active;
    logic first_rd;
    logic wr_pend;
    logic drive;
    logic [LANES-1:0] lane_we;
    ftb_sleep_e slp;
    logic [1:0] slp_cnt;
  } ftb_state_s;
  ftb_state_s st_r, st_nxt;

  function automatic logic ftb_is_write(input logic gw_n, input logic bwe_n, input logic [LANES-1:0] bw_n);
    return !gw_n || (!bwe_n && !(&bw_n));
  endfunction : ftb_is_write

  function automatic logic [LANES-1:0] ftb_lanes(input logic gw_n, input logic [LANES-1:0] bw_n);
    return gw_n ? ~bw_n : {LANES{1'b1}};
  endfunction : ftb_lanes

  logic [1:0] next_pair;
  logic [DW-1:0] rdata;
  logic sel_ok, p_start, c_start, wr_now, sleeping, drive_nxt;

  ftb_burst_seq u_seq (
    .cur_pair(st_r.addr[1:0]),
    .start_pair(st_r.start),
    .order_interleaved(burst_order),
    .next_pair(next_pair)
  );

  ftb_mem #(.AW(AW), .LANES(LANES), .LW(LW)) u_mem (
    .clk_sys(clk_sys),
    .addr(st_nxt.addr),
    .lane_we(st_nxt.lane_we),
    .wdata(data_in),
    .rdata(rdata)
  );

  // ---------------------------------
  // decode
  // ---------------------------------
  always_comb
  begin
    sleeping = (st_r.slp != FTB_AWAKE) || sleep_request;
    sel_ok = !chip_select_a_n && chip_select_b && !chip_select_c_n;
    p_start = !proc_addr_strobe_n && !chip_select_a_n;
    c_start = !ctrl_addr_strobe_n && !p_start;
    wr_now = ftb_is_write(global_write_n, byte_write_enable_n, byte_lane_select_n);
  end

  // ---------------------------------
  // next state
  // ---------------------------------
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.lane_we = '0;
    st_nxt.wr_pend = 1'b0;
    case (st_r.slp)
      FTB_AWAKE:
      begin
        if (sleep_request)
        begin
          st_nxt.slp_cnt = st_r.slp_cnt + 2'h1;
          if (st_r.slp_cnt == 2'(SLP - 1))
          begin
            st_nxt.slp = FTB_ASLEEP;
            st_nxt.slp_cnt = 2'h0;
          end
        end
        else
          st_nxt.slp_cnt = 2'h0;
      end
      FTB_ASLEEP:
      begin
        if (!sleep_request)
          st_nxt.slp = FTB_WAKING;
      end
      FTB_WAKING:
      begin
        st_nxt.slp_cnt = st_r.slp_cnt + 2'h1;
        if (sleep_request)
        begin
          st_nxt.slp = FTB_ASLEEP;
          st_nxt.slp_cnt = 2'h0;
        end
        else if (st_r.slp_cnt == 2'(SLP - 2))
        begin
          st_nxt.slp = FTB_AWAKE;
          st_nxt.slp_cnt = 2'h0;
        end
      end
      default:
        st_nxt.slp = FTB_AWAKE;
    endcase
    if (sleeping)
    begin
      st_nxt.active = 1'b0;
      st_nxt.drive = 1'b0;
      st_nxt.first_rd = 1'b0;
    end
    else if (p_start || c_start)
    begin
      if (sel_ok)
      begin
        st_nxt.addr = addr;
        st_nxt.start = addr[1:0];
        st_nxt.active = 1'b1;
        st_nxt.first_rd = !st_r.active;
        if (c_start && wr_now)
        begin
          st_nxt.lane_we = ftb_lanes(global_write_n, byte_lane_select_n);
          st_nxt.drive = 1'b0;
          st_nxt.wr_pend = 1'b1;
        end
        else
          st_nxt.drive = 1'b1;
      end
      else
      begin
        st_nxt.active = 1'b0;
        st_nxt.drive = 1'b0;
        st_nxt.first_rd = 1'b0;
      end
    end
    else if (st_r.active)
    begin
      if (!burst_advance_n)
        st_nxt.addr[1:0] = next_pair;
      else
        st_nxt.addr[1:0] = st_r.addr[1:0];
      st_nxt.first_rd = 1'b0;
      st_nxt.drive = !wr_now;
      st_nxt.wr_pend = wr_now;
      if (wr_now)
        st_nxt.lane_we = ftb_lanes(global_write_n, byte_lane_select_n);
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      st_r <= '{addr: '0, start: 2'h0, active: 1'b0, first_rd: 1'b0, wr_pend: 1'b0, drive: 1'b0,
                lane_we: '0, slp: FTB_AWAKE, slp_cnt: 2'h0};
      data_out <= '0;
      data_oe_n <= '1;
      asleep <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      data_out <= rdata;
      data_oe_n <= {DW{!drive_nxt}};
      asleep <= (st_nxt.slp != FTB_AWAKE);
    end
  end

  // ---------------------------------
  // data lines
  // ---------------------------------
  always_comb
  begin
    drive_nxt = st_nxt.drive && st_nxt.active && !st_nxt.wr_pend && !st_nxt.first_rd && !output_enable_n;
  end

  // ---------------------------------
  // checks
  // ---------------------------------
  a_proc_ignored: assert property (@(posedge clk_sys) disable iff (rst)
    (!proc_addr_strobe_n && chip_select_a_n && ctrl_addr_strobe_n && !sleeping && st_r.active)
    |=> st_r.active && st_r.addr[AW-1:2] == $past(st_r.addr[AW-1:2]))
    else $error("processor strobe not ignored");
  a_write_tristate: assert property (@(posedge clk_sys) disable iff (rst)
    st_r.wr_pend |-> &data_oe_n)
    else $error("data lines driven during write");
  a_sleep_entry: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(sleep_request) && st_r.slp == FTB_AWAKE && st_r.slp_cnt == 2'h0 ##1 sleep_request
    |=> st_r.slp == FTB_ASLEEP)
    else $error("sleep entry not two clocks");
  a_sleep_quiet: assert property (@(posedge clk_sys) disable iff (rst)
    (st_r.slp == FTB_ASLEEP) |-> (&data_oe_n && !st_r.active))
    else $error("activity while asleep");
  a_linear_step: assert property (@(posedge clk_sys) disable iff (rst)
    (st_r.active && !sleeping && !p_start && !c_start && !burst_advance_n && !burst_order)
    |=> st_r.addr[1:0] == $past(st_r.addr[1:0]) + 2'h1)
    else $error("linear step wrong");
  a_suspend_hold: assert property (@(posedge clk_sys) disable iff (rst)
    (st_r.active && !sleeping && !p_start && !c_start && burst_advance_n)
    |=> $stable(st_r.addr))
    else $error("suspend moved address");
  a_global_lanes: assert property (@(posedge clk_sys) disable iff (rst)
    (c_start && sel_ok && !sleeping && !global_write_n) |=> &st_r.lane_we)
    else $error("global write missed lanes");
  a_first_mask: assert property (@(posedge clk_sys) disable iff (rst)
    (!st_r.active && p_start && sel_ok && !sleeping) |=> &data_oe_n)
    else $error("output enable not masked");
  a_interleave_step: assert property (@(posedge clk_sys) disable iff (rst)
    (st_r.active && !sleeping && !p_start && !c_start && !burst_advance_n && burst_order)
    |=> (st_r.addr[1:0] ^ $past(st_r.addr[1:0])) == ((($past(st_r.addr[1:0]) ^ st_r.start) & 2'h1) != 2'h0 ? 2'h3 : 2'h1))
    else $error("interleaved step wrong");
  a_deselect_off: assert property (@(posedge clk_sys) disable iff (rst)
    ((p_start || c_start) && !sel_ok && !sleeping)
    |=> (!st_r.active && &data_oe_n))
    else $error("bad select did not deselect");
  a_oe_high_off: assert property (@(posedge clk_sys) disable iff (rst)
    $past(output_enable_n)
    |-> &data_oe_n)
    else $error("data lines driven with output enable high");
  a_oe_low_drive: assert property (@(posedge clk_sys) disable iff (rst)
    (st_r.active && !sleeping && !p_start && !c_start && !wr_now && !output_enable_n)
    |=> data_oe_n == '0)
    else $error("continued read not driven");
  a_wake_time: assert property (@(posedge clk_sys) disable iff (rst)
    (st_r.slp == FTB_ASLEEP && !sleep_request) ##1 !sleep_request
    |=> st_r.slp == FTB_AWAKE)
    else $error("sleep exit not two clocks");
  a_asleep_flag: assert property (@(posedge clk_sys) disable iff (rst)
    (st_r.slp == FTB_ASLEEP)
    |-> asleep)
    else $error("asleep flag low in sleep");
  a_sleep_hold: assert property (@(posedge clk_sys) disable iff (rst)
    sleeping
    |=> (!st_r.active && &data_oe_n))
    else $error("access taken during sleep");
  a_lane_write: assert property (@(posedge clk_sys) disable iff (rst)
    (c_start && sel_ok && !sleeping && global_write_n && !byte_write_enable_n && !(&byte_lane_select_n))
    |=> st_r.lane_we == ~$past(byte_lane_select_n))
    else $error("byte lanes wrong");
  a_global_cont: assert property (@(posedge clk_sys) disable iff (rst)
    (st_r.active && !sleeping && !p_start && !c_start && !global_write_n)
    |=> &st_r.lane_we)
    else $error("continued global write missed lanes");
  a_ctrl_load: assert property (@(posedge clk_sys) disable iff (rst)
    (c_start && sel_ok && !sleeping)
    |=> st_r.addr == $past(addr))
    else $error("controller strobe address not loaded");
  a_ctrl_write: assert property (@(posedge clk_sys) disable iff (rst)
    (c_start && sel_ok && !sleeping && wr_now)
    |=> (st_r.wr_pend && &data_oe_n))
    else $error("controller write not started");
  a_proc_read: assert property (@(posedge clk_sys) disable iff (rst)
    (p_start && sel_ok && !sleeping)
    |=> (!st_r.wr_pend && st_r.lane_we == '0))
    else $error("processor start wrote data");
  a_both_strobes: assert property (@(posedge clk_sys) disable iff (rst)
    (!proc_addr_strobe_n && !ctrl_addr_strobe_n && sel_ok && !sleeping)
    |=> (!st_r.wr_pend && st_r.addr == $past(addr)))
    else $error("controller strobe acted with processor strobe");
endmodule : ftb_sram_port
`default_nettype wire

// *** hw/ftb_defines.svh ***
/*
  Constants for the flow-through burst SRAM port: burst orders, timing counts, widths.
  Assumes a 50 MHz system clock; included by every design and verification module, not by the package.
*/
// Contract
// - Every synchronous input is registered on the rising clock edge.
// - Two-bit wraparound burst counter loads from address low bits on new address.
// - Order strap low selects linear, high or floating selects interleaved; the code decodes a floating strap as linear.
// - Interleaved order XORs start pair with 01, 10, 11.
// - Linear order increments start pair modulo four.
// - Processor strobe is ignored when first chip select is high.
// - Read starts with all selects active and a strobe low; host keeps writes idle.
// - Processor-strobe start ignores write inputs in its first cycle.
// - Controller-strobe start with write indication and processor strobe high writes.
// - Lane writes gated by byte write enable; global write writes all lanes.
// - Data lines tristate whenever a write is detected, whatever output enable does.
// - Sleep entry and exit each take two clocks; memory contents kept.
// - During sleep all other inputs are ignored and data lines tristate.
// - Deselect and tristate on bad chip selects at an access start.
// - No new address and advance low steps to next burst address.
// - No new address and advance high repeats current burst address.
// - Reads drive data when output enable low, tristate when high.
// - Controller-strobe write takes data regardless of output enable.
// - Write when global write low, or byte enable low with any lane low.
// - Output enable masked first read clock after deselect.
// - Parity lines written under their own byte lane select.
`ifndef FTB_DEFINES_SVH
`define FTB_DEFINES_SVH
`define FTB_CLK_PERIOD_NS 20
`define FTB_SLEEP_CYCLES 2
`define FTB_ADDR_W 10
`define FTB_LANES 4
`define FTB_LANE_W 9
`define FTB_ORDER_LINEAR 1'b0
`define FTB_ORDER_INTERLEAVED 1'b1
`endif

// *** hw/ftb_pkg.sv ***
/*
  Types for the flow-through burst SRAM port.
  Assumes ftb_defines.svh is on the include path.
*/
package ftb_pkg;
  typedef enum logic [2:0] {
    FTB_AWAKE = 3'h1,
    FTB_ASLEEP = 3'h2,
    FTB_WAKING = 3'h4
  } ftb_sleep_e;
endpackage : ftb_pkg

// *** hw/ftb_burst_seq.sv ***
/*
  Next burst low-address-pair generator.
  Assumes a static order strap.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ftb_defines.svh"
module ftb_burst_seq
(
  // burst pair
  input wire logic [1:0] cur_pair,
  input wire logic [1:0] start_pair,
  input wire logic order_interleaved,
  output logic [1:0] next_pair
);
  // -----------------------------
  // step
  // -----------------------------
  function automatic logic [1:0] ftb_step(input logic [1:0] p, input logic [1:0] s, input logic il);
    logic [1:0] r;
    r = 2'h0;
    if (il == `FTB_ORDER_INTERLEAVED)
      r = s ^ ((s ^ p) + 2'h1);
    else
      r = p + 2'h1;
    return r;
  endfunction : ftb_step
  assign next_pair = ftb_step(cur_pair, start_pair, order_interleaved);
endmodule : ftb_burst_seq
`default_nettype wire

// *** hw/ftb_mem.sv ***
/*
  Memory array with per-lane write and flow-through read.
  Assumes writes and read share one address, the port's next-state address before its register.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ftb_defines.svh"
module ftb_mem #(
  parameter int AW = `FTB_ADDR_W,
  parameter int LANES = `FTB_LANES,
  parameter int LW = `FTB_LANE_W
)
(
  // clock
  input wire logic clk_sys,
  // access
  input wire logic [AW-1:0] addr,
  input wire logic [LANES-1:0] lane_we,
  input wire logic [LANES*LW-1:0] wdata,
  output logic [LANES*LW-1:0] rdata
);
  logic [LANES*LW-1:0] mem [0:(1<<AW)-1];
  always_ff @(posedge clk_sys)
  begin
    for (int i = 0; i < LANES; i++)
      if (lane_we[i])
        mem[addr][i*LW +: LW] <= wdata[i*LW +: LW];
  end
  assign rdata = mem[addr];
endmodule : ftb_mem
`default_nettype wire

// *** verif/ftb_host_model.sv ***
/*
  Host model for the SRAM port: one bus cycle per cyc call, driven at the falling edge.
  Assumes it shares clk_sys with the port; ctl is {strobe p, strobe c, advance, select a, b, c, oe}.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ftb_defines.svh"
module ftb_host_model
(
  // clock
  input wire logic clk_sys,
  // control
  output var logic [`FTB_ADDR_W-1:0] addr,
  output var logic [6:0] ctl,
  output var logic [5:0] wr,
  output var logic sleep_request,
  // data lines as the port sees them
  output var logic [`FTB_LANES*`FTB_LANE_W-1:0] data_in
);
  logic [`FTB_LANES*`FTB_LANE_W-1:0] wd;
  logic drv;
  // released lines show the inverse of the last value
  assign data_in = drv ? wd : ~wd;
  initial
  begin
    addr = '0;
    ctl = 7'h75;
    wr = 6'h3F;
    wd = '0;
    drv = 1'b0;
    sleep_request = 1'b0;
  end
  // ----------------------------------------
  // bus cycles
  // ----------------------------------------
  task cyc(input logic [6:0] c, input logic [9:0] a, input logic [5:0] w, input logic [35:0] d);
    logic wrt;
    begin
      wrt = !w[5] || (!w[4] && !(&w[3:0]));
      @(negedge clk_sys);
      addr = a;
      ctl = {c[6:1], c[0] | wrt};
      wr = w;
      wd = d;
      drv = wrt;
    end
  endtask : cyc
  task nap(input logic v);
    begin
      cyc(v ? 7'h5D : 7'h7B, addr, 6'h3F, wd);
      @(negedge clk_sys);
      sleep_request = v;
      repeat (2) cyc(7'h7B, addr, 6'h3F, wd);
    end
  endtask : nap
endmodule : ftb_host_model
`default_nettype wire

// *** verif/test_flow_through_burst_sram_port.sv ***
/*
  Self-checking bench for the flow-through burst SRAM port.
  Assumes ftb_host_model drives every port input but clk_sys, rst and burst_order; checks just after selected rising edges.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ftb_defines.svh"
module test_flow_through_burst_sram_port;
  localparam int DW = `FTB_LANES * `FTB_LANE_W;
  localparam logic [DW-1:0] OFF = {DW{1'b1}};
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic burst_order = 1'b1;
  logic sleep_request, asleep;
  logic [`FTB_ADDR_W-1:0] addr;
  logic [6:0] ctl;
  logic [5:0] wr;
  logic [DW-1:0] data_in, data_out, data_oe_n;
  logic [DW-1:0] mem [int];
  int n_mismatch = 0;
  int n_checks = 0;
  always #10 clk_sys = ~clk_sys;
  ftb_host_model host (.clk_sys(clk_sys), .addr(addr), .ctl(ctl), .wr(wr),
    .sleep_request(sleep_request), .data_in(data_in));
  ftb_sram_port DUT (.clk_sys(clk_sys), .rst(rst), .addr(addr), .proc_addr_strobe_n(ctl[6]),
    .ctrl_addr_strobe_n(ctl[5]), .burst_advance_n(ctl[4]), .chip_select_a_n(ctl[3]),
    .chip_select_b(ctl[2]), .chip_select_c_n(ctl[1]), .output_enable_n(ctl[0]),
    .global_write_n(wr[5]), .byte_write_enable_n(wr[4]), .byte_lane_select_n(wr[3:0]),
    .sleep_request(sleep_request), .burst_order(burst_order), .data_in(data_in),
    .data_out(data_out), .data_oe_n(data_oe_n), .asleep(asleep));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task chk(input string what, input logic [DW-1:0] exp, input logic [DW-1:0] got);
    begin
      n_checks++;
      if (got !== exp)
      begin
        n_mismatch++;
        $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
    end
  endtask : chk
  task smp;
    @(posedge clk_sys) #5;
  endtask : smp
  task results;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask : results
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_burst(input logic ord, input logic [1:0] s);
    logic [1:0] p;
    logic [9:0] a;
    begin
      @(negedge clk_sys) burst_order = ord;
      for (int k = 0; k < 4; k++)
      begin
        p = ord ? s ^ 2'(k) : s + 2'(k);
        a = {8'h12, p};
        mem[a] = {a, ~a, 4'(k), ord, s, 9'h1C7};
        host.cyc(k ? 7'h64 : 7'h55, {8'h12, s}, 6'h1F, mem[a]);
        smp();
        chk("write oe", OFF, data_oe_n);
      end
      for (int k = 0; k < 4; k++)
      begin
        p = ord ? s ^ 2'(k) : s + 2'(k);
        host.cyc(k ? 7'h64 : 7'h34, {8'h12, s}, 6'h3F, '0);
        smp();
        chk("burst data", mem[{8'h12, p}], data_out);
        chk("burst oe", '0, data_oe_n);
      end
      $display("test burst done");
    end
  endtask : t_burst
  task t_lanes;
    logic [DW-1:0] m;
    begin
      m = {9'h000, 9'h1FF, 9'h000, 9'h1FF};
      host.cyc(7'h55, 10'h040, 6'h07, 36'h123456789);
      host.cyc(7'h55, 10'h040, 6'h2A, 36'hFEDCBA987);
      host.cyc(7'h54, 10'h040, 6'h2F, 36'h0F0F0F0F0);
      smp();
      chk("lane data", (36'hFEDCBA987 & m) | (36'h123456789 & ~m), data_out);
      chk("lane oe", '0, data_oe_n);
      $display("test lanes done");
    end
  endtask : t_lanes
  task t_proc;
    begin
      host.cyc(7'h14, 10'h048, 6'h1F, 36'hAAAAAAAAA);
      host.cyc(7'h74, 10'h048, 6'h3F, '0);
      smp();
      chk("strobe start read", mem[10'h048], data_out);
      host.cyc(7'h74, 10'h048, 6'h1F, 36'h5A5A5A5A5);
      mem[10'h048] = 36'h5A5A5A5A5;
      host.cyc(7'h3C, 10'h3FF, 6'h3F, '0);
      smp();
      chk("ignored strobe", mem[10'h048], data_out);
      $display("test proc done");
    end
  endtask : t_proc
  task t_desel;
    logic [6:0] c [3];
    begin
      c = '{7'h50, 7'h36, 7'h5C};
      foreach (c[i])
      begin
        host.cyc(c[i], 10'h3FF, 6'h3F, '0);
        smp();
        chk("deselect oe", OFF, data_oe_n);
      end
      $display("test deselect done");
    end
  endtask : t_desel
  task t_sleep;
    begin
      host.nap(1'b1);
      host.cyc(7'h55, 10'h048, 6'h1F, 36'h0);
      host.cyc(7'h54, 10'h048, 6'h3F, '0);
      smp();
      chk("asleep", 36'h1, DW'(asleep));
      chk("sleep oe", OFF, data_oe_n);
      host.nap(1'b0);
      host.cyc(7'h34, 10'h048, 6'h3F, '0);
      smp();
      chk("awake", '0, DW'(asleep));
      chk("first read oe", OFF, data_oe_n);
      host.cyc(7'h74, 10'h048, 6'h3F, '0);
      smp();
      chk("kept data", mem[10'h048], data_out);
      $display("test sleep done");
    end
  endtask : t_sleep
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial
  begin
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys) rst = 1'b0;
    smp();
    chk("reset oe", OFF, data_oe_n);
    chk("reset asleep", '0, DW'(asleep));
    for (int o = 0; o < 2; o++)
    begin
      t_burst(o[0], 2'b01);
      t_burst(o[0], 2'b10);
    end
    t_lanes();
    t_proc();
    t_desel();
    t_sleep();
    results();
  end
  // the tests need under two hundred cycles; two thousand means a hang
  initial
  begin
    #40000;
    n_mismatch++;
    results();
  end
endmodule : test_flow_through_burst_sram_port
`default_nettype wire
